//--- verilog/idc_map.vh
// Purpose: Register indices, field positions and reset values of the idle control block
// Assumes: Register byte address is four times its index
// Notes: Definitions only
`ifndef IDC_MAP_VH
`define IDC_MAP_VH

// Register indices
`define IDC_IDX_CONFIG 18'h0_0001
`define IDC_IDX_STATUS 18'h0_0002
`define IDC_IDX_PMASK 18'h0_9400
`define IDC_IDX_IRQ_STAT 18'h0_0010
`define IDC_IDX_IRQ_MASK 18'h0_0011

// Field positions, shared by config and status up to bit 8; CLKEXT is config only
`define IDC_BIT_CPU 0
`define IDC_BIT_MASTER 1
`define IDC_BIT_INSTRUCTION_CACHE 2
`define IDC_BIT_PERIPHERAL_GROUP_IDLE_REQUEST 3
`define IDC_BIT_CLKGEN 4
`define IDC_BIT_EXTERNAL_MEMORY_INTERFACE 5
`define IDC_BIT_XPORT 6
`define IDC_BIT_MPORT 7
`define IDC_BIT_IPORT 8
`define IDC_BIT_CLKEXT 9

// Writable masks
`define IDC_CONFIG_WMASK 16'h0_3FF
`define IDC_PMASK_WMASK 16'h3_FFF
`define IDC_IRQ_WMASK 2'h3

// Values needed by clock generator idle, apart from its own bit
`define IDC_CLK_COMPANIONS 10'h3_E7

// Interrupt status bits
`define IDC_IRQ_BUS_ERROR 0
`define IDC_IRQ_IDLE_ENTERED 1

// Reset values
`define IDC_CONFIG_RESET 16'h0_000
`define IDC_STATE_RESET 9'h0_00
`define IDC_PMASK_RESET 16'h0_000
`define IDC_IRQ_RESET 2'h0

`endif

//--- verilog/idc_top.v
// Purpose: Idle domain configuration with idle entry, check and status over APB
// Assumes: Runs on an always-on clock; IDLE_EXEC and WAKE_REQ are one-cycle same-clock pulses
// Notes: Domain outputs are levels held until WAKE_REQ or the next IDLE_EXEC; PERIPH_IDLE also follows PMASK writes
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "idc_map.vh"

module idc_top #(
    parameter PMASK_W = 14
) (
    input wire CLK,
    input wire RST_N,
    input wire [17:0] PADDR,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire IDLE_EXEC,
    input wire WAKE_REQ,
    output reg CPU_IDLE,
    output reg MASTER_PERIPH_IDLE,
    output reg INSTRUCTION_CACHE_IDLE,
    output reg [PMASK_W-1:0] PERIPH_IDLE,
    output reg CLKGEN_IDLE,
    output reg SYSCLK_STOP,
    output reg EXTERNAL_MEMORY_INTERFACE_IDLE,
    output reg XPORT_IDLE,
    output reg MPORT_IDLE,
    output reg IPORT_IDLE,
    output reg BUS_ERROR_IRQ,
    output reg IRQ
);

    reg [15:0] config_reg;
    reg [15:0] config_next;
    reg [8:0] state_reg;
    reg [8:0] state_next;
    reg [15:0] pmask_reg;
    reg [15:0] pmask_next;
    reg [1:0] irq_stat_reg;
    reg [1:0] irq_stat_next;
    reg [1:0] irq_mask_reg;
    reg [1:0] irq_mask_next;
    reg [31:0] rdata_next;
    reg slverr_next;
    reg [PMASK_W-1:0] periph_next;

    wire access_phase;
    wire done;
    wire wr_done;
    wire rd_done;
    wire clk_req;
    wire companions_ok;
    wire bus_error;
    wire idle_ok;
    wire [1:0] irq_set;
    wire [1:0] irq_clr;

    // Index from a word-aligned byte address
    function [17:0] idc_index;
        input [17:0] addr;
        begin
            idc_index = {2'b00, addr[17:2]};
        end
    endfunction

    function idc_hit;
        input [17:0] addr;
        input [17:0] index;
        begin
            idc_hit = (idc_index(addr) == index) && (addr[1:0] == 2'b00);
        end
    endfunction

    function idc_mapped;
        input [17:0] addr;
        begin
            if (idc_hit(addr, `IDC_IDX_CONFIG)) begin
                idc_mapped = 1'b1;
            end else if (idc_hit(addr, `IDC_IDX_STATUS)) begin
                idc_mapped = 1'b1;
            end else if (idc_hit(addr, `IDC_IDX_PMASK)) begin
                idc_mapped = 1'b1;
            end else if (idc_hit(addr, `IDC_IDX_IRQ_STAT)) begin
                idc_mapped = 1'b1;
            end else if (idc_hit(addr, `IDC_IDX_IRQ_MASK)) begin
                idc_mapped = 1'b1;
            end else begin
                idc_mapped = 1'b0;
            end
        end
    endfunction

    // One wait state: PREADY rises in the second access cycle
    assign access_phase = PSEL && PENABLE && !PREADY;
    assign done = PSEL && PENABLE && PREADY;
    assign wr_done = done && PWRITE && !PSLVERR;
    assign rd_done = done && !PWRITE && !PSLVERR;

    assign clk_req = config_reg[`IDC_BIT_CLKGEN];
    // Extended bit and all port and core bits must accompany the clock request
    assign companions_ok = ((config_reg[9:0] & `IDC_CLK_COMPANIONS)
                           == `IDC_CLK_COMPANIONS);
    assign bus_error = IDLE_EXEC && clk_req && !companions_ok;
    assign idle_ok = IDLE_EXEC && !bus_error;

    assign irq_set[`IDC_IRQ_BUS_ERROR] = bus_error;
    assign irq_set[`IDC_IRQ_IDLE_ENTERED] = idle_ok;
    // Reading the interrupt status clears it; a new event still wins
    assign irq_clr = (rd_done && idc_hit(PADDR, `IDC_IDX_IRQ_STAT)) ? 2'b11 : 2'b00;

    // Bus side
    always @* begin
        rdata_next = 32'h0000_0000;
        slverr_next = 1'b0;
        if (access_phase) begin
            slverr_next = !idc_mapped(PADDR);
            if (idc_hit(PADDR, `IDC_IDX_CONFIG)) begin
                rdata_next = {16'h0000, config_reg};
            end else if (idc_hit(PADDR, `IDC_IDX_STATUS)) begin
                rdata_next = {23'h00_0000, state_reg};
            end else if (idc_hit(PADDR, `IDC_IDX_PMASK)) begin
                rdata_next = {16'h0000, pmask_reg};
            end else if (idc_hit(PADDR, `IDC_IDX_IRQ_STAT)) begin
                rdata_next = {30'h0000_0000, irq_stat_reg};
            end else if (idc_hit(PADDR, `IDC_IDX_IRQ_MASK)) begin
                rdata_next = {30'h0000_0000, irq_mask_reg};
            end else begin
                rdata_next = 32'h0000_0000;
            end
        end
    end

    // Register writes
    always @* begin
        config_next = config_reg;
        pmask_next = pmask_reg;
        irq_mask_next = irq_mask_reg;
        if (wr_done) begin
            // Storing config requests has no effect on the domains yet; a PMASK write regates PERIPH_IDLE one clock after pmask_reg updates
            if (idc_hit(PADDR, `IDC_IDX_CONFIG)) begin
                config_next = PWDATA[15:0] & `IDC_CONFIG_WMASK;
            end else if (idc_hit(PADDR, `IDC_IDX_PMASK)) begin
                pmask_next = PWDATA[15:0] & `IDC_PMASK_WMASK;
            end else if (idc_hit(PADDR, `IDC_IDX_IRQ_MASK)) begin
                irq_mask_next = PWDATA[1:0] & `IDC_IRQ_WMASK;
            end else begin
                config_next = config_reg;
            end
        end
    end

    // Idle entry and wake
    always @* begin
        state_next = state_reg;
        if (WAKE_REQ) begin
            state_next = `IDC_STATE_RESET;
        end else if (idle_ok) begin
            // Config bits latch into the domain state only on the idle instruction
            state_next = config_reg[8:0];
        end else if (bus_error) begin
            state_next = `IDC_STATE_RESET;
        end
    end

    always @* begin
        irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
    end

    // Peripheral gating by mask, one bit each
    genvar gi;
    generate
        for (gi = 0; gi < PMASK_W; gi = gi + 1) begin : g_periph
            always @* begin
                periph_next[gi] = state_next[`IDC_BIT_PERIPHERAL_GROUP_IDLE_REQUEST] && pmask_reg[gi];
            end
        end
    endgenerate

    // Software-visible registers, one process each
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            config_reg <= `IDC_CONFIG_RESET;
        end else begin
            config_reg <= config_next;
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= `IDC_STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pmask_reg <= `IDC_PMASK_RESET;
        end else begin
            pmask_reg <= pmask_next;
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_stat_reg <= `IDC_IRQ_RESET;
        end else begin
            irq_stat_reg <= irq_stat_next;
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            irq_mask_reg <= `IDC_IRQ_RESET;
        end else begin
            irq_mask_reg <= irq_mask_next;
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PRDATA <= rdata_next;
            PREADY <= access_phase;
            PSLVERR <= slverr_next;
        end
    end

    // Domain outputs follow the next state so they align with the status register
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CPU_IDLE <= 1'b0;
        end else begin
            CPU_IDLE <= state_next[`IDC_BIT_CPU];
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            MASTER_PERIPH_IDLE <= 1'b0;
        end else begin
            MASTER_PERIPH_IDLE <= state_next[`IDC_BIT_MASTER];
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            INSTRUCTION_CACHE_IDLE <= 1'b0;
        end else begin
            INSTRUCTION_CACHE_IDLE <= state_next[`IDC_BIT_INSTRUCTION_CACHE];
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PERIPH_IDLE <= {PMASK_W{1'b0}};
        end else begin
            PERIPH_IDLE <= periph_next;
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CLKGEN_IDLE <= 1'b0;
        end else begin
            CLKGEN_IDLE <= state_next[`IDC_BIT_CLKGEN];
        end
    end

    // Clock generator idle is the deepest state: system clock halts
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SYSCLK_STOP <= 1'b0;
        end else begin
            SYSCLK_STOP <= state_next[`IDC_BIT_CLKGEN];
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            EXTERNAL_MEMORY_INTERFACE_IDLE <= 1'b0;
        end else begin
            EXTERNAL_MEMORY_INTERFACE_IDLE <= state_next[`IDC_BIT_EXTERNAL_MEMORY_INTERFACE];
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            XPORT_IDLE <= 1'b0;
        end else begin
            XPORT_IDLE <= state_next[`IDC_BIT_XPORT];
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            MPORT_IDLE <= 1'b0;
        end else begin
            MPORT_IDLE <= state_next[`IDC_BIT_MPORT];
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            IPORT_IDLE <= 1'b0;
        end else begin
            IPORT_IDLE <= state_next[`IDC_BIT_IPORT];
        end
    end

    // One-cycle pulse per rejected idle instruction
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            BUS_ERROR_IRQ <= 1'b0;
        end else begin
            BUS_ERROR_IRQ <= bus_error;
        end
    end

    // Built from next values so the level matches the status a read would see
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_stat_next & irq_mask_next);
        end
    end

endmodule // idc_top

//--- tb/idc_chk.sv
// Purpose: Port-level checker for the idle domain block
// Assumes: Config word tracked from completed APB writes
// Notes: Bound to idc_top
`timescale 1ns/100ps
module idc_chk #(parameter PMASK_W = 14) (
    input wire CLK, input wire RST_N, input wire [17:0] PADDR, input wire PSEL,
    input wire PENABLE, input wire PWRITE, input wire [31:0] PWDATA,
    input wire [31:0] PRDATA, input wire PREADY, input wire PSLVERR,
    input wire IDLE_EXEC, input wire WAKE_REQ, input wire CPU_IDLE,
    input wire MASTER_PERIPH_IDLE, input wire INSTRUCTION_CACHE_IDLE,
    input wire [PMASK_W-1:0] PERIPH_IDLE, input wire CLKGEN_IDLE,
    input wire SYSCLK_STOP, input wire EXTERNAL_MEMORY_INTERFACE_IDLE, input wire XPORT_IDLE,
    input wire MPORT_IDLE, input wire IPORT_IDLE, input wire BUS_ERROR_IRQ,
    input wire IRQ
);
    reg [9:0] cfg_reg;
    wire bad = cfg_reg[4] && ((cfg_reg & 10'h3E7) != 10'h3E7);
    wire go = IDLE_EXEC && !WAKE_REQ && !bad;
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) cfg_reg <= 10'h000;
        else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 18'h0_0004)
            cfg_reg <= PWDATA[9:0];
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    err_pulse_a: assert property (IDLE_EXEC && bad |=> BUS_ERROR_IRQ)
        else $error("bus error missing");
    err_once_a: assert property (!(IDLE_EXEC && bad) |=> !BUS_ERROR_IRQ)
        else $error("stray bus error");
    err_abort_a: assert property (IDLE_EXEC && bad |=> !CPU_IDLE && !CLKGEN_IDLE)
        else $error("idle entered on error");
    clk_idle_a: assert property (go |=> CLKGEN_IDLE == $past(cfg_reg[4]))
        else $error("clock idle wrong");
    sysclk_stop_a: assert property (SYSCLK_STOP == CLKGEN_IDLE)
        else $error("sysclk stop mismatch");
    cpu_idle_a: assert property (go |=> CPU_IDLE == $past(cfg_reg[0]))
        else $error("cpu idle wrong");
    cache_mst_a: assert property (go |=> {INSTRUCTION_CACHE_IDLE, MASTER_PERIPH_IDLE} == $past(cfg_reg[2:1]))
        else $error("cache or master idle wrong");
    write_hold_a: assert property (!IDLE_EXEC && !WAKE_REQ |=> $stable(CPU_IDLE) && $stable(CLKGEN_IDLE))
        else $error("domain moved without idle");
    periph_off_a: assert property (go && !cfg_reg[3] |=> PERIPH_IDLE == 0)
        else $error("peripherals idled");
    cover property (IDLE_EXEC && bad);
    cover property (go && cfg_reg[4]);
    cover property (IRQ);
endmodule // idc_chk
bind idc_top idc_chk #(.PMASK_W(PMASK_W)) u_chk (.*);

//--- tb/test_idc_top.sv
// Purpose: Self-checking bench for the idle domain block
// Assumes: One wait state on APB
// Notes: Seeded random configs plus corners
`timescale 1ns/100ps
module test_idc_top;
    reg CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, IDLE_EXEC = 0, WAKE_REQ = 0;
    reg [17:0] PADDR = 0;
    reg [31:0] PWDATA = 0, rd, cfg, pm;
    reg se, err;
    wire [31:0] PRDATA;
    wire [13:0] PERIPH_IDLE;
    wire PREADY, PSLVERR, CPU_IDLE, MASTER_PERIPH_IDLE, INSTRUCTION_CACHE_IDLE, CLKGEN_IDLE, SYSCLK_STOP;
    wire EXTERNAL_MEMORY_INTERFACE_IDLE, XPORT_IDLE, MPORT_IDLE, IPORT_IDLE, BUS_ERROR_IRQ, IRQ;
    integer error_cnt = 0, checks_done = 0, i;
    always #10 CLK = ~CLK;
    idc_top u_dut (.*);
    task test_done;
        begin
            $display("checks %0d errors %0d", checks_done, error_cnt);
            if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input [63:0] nm, input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("ERROR %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task apb(input w, input [17:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge CLK);
            PSEL <= 1;
            PWRITE <= w;
            PADDR <= a;
            PWDATA <= d;
            @(posedge CLK);
            PENABLE <= 1;
            k = 0;
            do begin
                @(posedge CLK);
                k = k + 1;
            end while (!PREADY && k < 20);
            if (!PREADY) error_cnt = error_cnt + 1;
            rd = PRDATA;
            se = PSLVERR;
            PSEL <= 0;
            PENABLE <= 0;
        end
    endtask
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        test_done;
    end
    initial begin
        i = $urandom(38);
        repeat (10) @(posedge CLK);
        RST_N <= 1;
        apb(0, 18'h0_0004, 0);
        chk("cfgrst", rd, 0);
        apb(0, 18'h0_0008, 0);
        chk("strst", rd, 0);
        apb(0, 18'h0_0100, 0);
        chk("unmap", se, 1);
        for (i = 0; i < 24; i = i + 1) begin
            case (i)
                0: cfg = 32'h0000_0000;
                1: cfg = 32'h0000_0010;
                2: cfg = 32'h0000_0210;
                3: cfg = 32'h0000_03FF;
                4: cfg = 32'h0000_03F7;
                default: cfg = ($urandom & 32'h0000_03FF) | (i > 12 ? 32'h0000_03E7 : 0);
            endcase
            pm = $urandom & 32'h0000_3FFF;
            err = cfg[4] && ((cfg[9:0] & 10'h3E7) != 10'h3E7);
            apb(1, 18'h0_0044, i & 1);
            apb(1, 18'h2_5000, pm);
            apb(1, 18'h0_0004, cfg | 32'hFFFF_0000);
            apb(0, 18'h0_0004, 0);
            chk("cfg", rd, cfg);
            chk("noidle", {CPU_IDLE, CLKGEN_IDLE}, 0);
            IDLE_EXEC <= 1;
            @(posedge CLK);
            IDLE_EXEC <= 0;
            #1;
            chk("buserr", BUS_ERROR_IRQ, err);
            chk("irq", IRQ, err & i[0]);
            chk("clk", {SYSCLK_STOP, CLKGEN_IDLE}, err ? 0 : {2{cfg[4]}});
            chk("cpu", CPU_IDLE, !err & cfg[0]);
            chk("ports", {IPORT_IDLE, MPORT_IDLE, XPORT_IDLE, EXTERNAL_MEMORY_INTERFACE_IDLE}, err ? 0 : cfg[8:5]);
            chk("mst", MASTER_PERIPH_IDLE, !err & cfg[1]);
            chk("instruction_cache", INSTRUCTION_CACHE_IDLE, !err & cfg[2]);
            chk("periph", PERIPH_IDLE, (!err & cfg[3]) ? pm : 0);
            apb(0, 18'h0_0008, 0);
            chk("status", rd, err ? 0 : cfg[8:0]);
            apb(0, 18'h0_0040, 0);
            chk("irqst", rd[1:0], {!err, err});
            apb(0, 18'h0_0040, 0);
            chk("irqclr", rd[1:0], 0);
            WAKE_REQ <= 1;
            @(posedge CLK);
            WAKE_REQ <= 0;
        end
        test_done;
    end
endmodule // test_idc_top
